// ---- eti_defs.vh ----
`ifndef ETI_DEFS_VH
`define ETI_DEFS_VH
// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ETI_ADDR_TSC 12'h008
`define ETI_ADDR_XSC 12'h00c
`define ETI_ADDR_CPU 12'h010
`define ETI_ADDR_OPT 12'h014
// ----------------------------------------
// Timer status/control fields
// ----------------------------------------
`define ETI_TSC_OVF 7
`define ETI_TSC_RTF 6
`define ETI_TSC_OVE 5
`define ETI_TSC_RTE 4
`define ETI_TSC_OVCLR 3
`define ETI_TSC_RTCLR 2
`define ETI_TSC_RESET 8'h03
// ----------------------------------------
// External status/control fields
// ----------------------------------------
`define ETI_XSC_GEN 7
`define ETI_XSC_PEND 3
`define ETI_XSC_ACK 1
// ----------------------------------------
// Option fields
// ----------------------------------------
`define ETI_OPT_LEVEL 0
`define ETI_OPT_PORTA 1
// ----------------------------------------
// Vectors and memory map
// ----------------------------------------
`define ETI_VEC_SWI 11'h7fc
`define ETI_VEC_EXT 11'h7fa
`define ETI_VEC_TMR 11'h7f8
`define ETI_RAM_LO 11'h0c0
`define ETI_RAM_HI 11'h0ff
`define ETI_ROM_LO 11'h300
`define ETI_ROM_HI 11'h7ff
// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define ETI_ST_IDLE 2'h0
`define ETI_ST_STACK 2'h1
`define ETI_ST_VECT 2'h2
`define ETI_ST_UNST 2'h3
`define ETI_STACK_BYTES 3'h5
`endif

// ---- eti_sync.v ----
module eti_sync (
   input wire ref_clk,
   input wire rst_sync_n,
   input wire clk_en,
   input wire [4:0] din,
   output wire [4:0] dout
);
   reg [4:0] meta;
   reg [4:0] stable;
   // Reset to the idle pin levels so no edge appears at release
   always @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         meta <= 5'h01;
         stable <= 5'h01;
      end else if (clk_en) begin
         meta <= din;
         stable <= meta;
      end
   end
   assign dout = stable;
endmodule

// ---- eti_core.v ----
// Overview of operation
// - Opcode fetch outside RAM and program ROM produces a reset pulse.
// - Entering external interrupt service clears the external request latch.
// - Request latched in service is taken as soon as return clears mask.
// - Mask bit set blocks external and timer requests from service.
// - Port A option lets low four port A pins request interrupts.
// - Sensitivity option picks falling edge only or edge plus low level.
// - Port A inputs use same option with rising edge or high level.
// - Level mode keeps request latched while any source holds pin active.
// - Edge-and-level mode latches on falling edge or low level.
// - Edge mode relatches only after pin returns high then falls again.
// - Enabled port A pins act like the pin with inverted sense.
// - Port A pins enabled as one group by single enable bit.
// - Real-time flag set with its enable requests timer interrupt.
// - Overflow flag set with its enable requests timer interrupt.
// - Accepting an interrupt stacks registers, sets mask, loads vector.
// - Return restores stacked registers in reverse order of entry.
// - Request arriving while masked stays pending until mask clears.
// - Every reset sets the mask; only software clears it.
// - Timer register: overflow b7, real-time b6, enables b5 and b4.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`include "eti_defs.vh"
module eti_core (
   input wire ref_clk,
   input wire rst_n,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire irq_pin_n,
   input wire [3:0] porta_low_pins,
   input wire realtime_event,
   input wire overflow_event,
   input wire software_trap,
   input wire return_from_exception,
   input wire mask_set_cmd,
   input wire mask_clear_cmd,
   input wire fetch_valid,
   input wire [10:0] fetch_addr,
   output reg illegal_reset,
   output reg int_mask,
   output reg stack_push,
   output reg stack_pop,
   output reg [2:0] stack_index,
   output reg vector_load,
   output reg [10:0] vector_addr,
   output reg in_service
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   reg rst_meta;
   reg rst_sync_n;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   wire [4:0] pins_sync;
   eti_sync u_sync (
      .ref_clk(ref_clk),
      .rst_sync_n(rst_sync_n),
      .clk_en(clk_en),
      .din({porta_low_pins, irq_pin_n}),
      .dout(pins_sync)
   );

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] timer_status_control;
   reg porta_group_enable;
   reg [1:0] mask_option_reg;
   reg ext_latch;
   reg irq_prev;
   reg pa_prev;
   reg [1:0] state;
   reg [1:0] src;
   reg [2:0] count;
   // Arbitration result, settled before the sequencer edge
   reg [1:0] next_src;
   reg next_take;

   // Sequencer states and request sources
   localparam [1:0] ST_IDLE = `ETI_ST_IDLE;
   localparam [1:0] ST_STACK = `ETI_ST_STACK;
   localparam [1:0] ST_VECT = `ETI_ST_VECT;
   localparam [1:0] ST_UNST = `ETI_ST_UNST;
   localparam [1:0] SRC_TMR = 2'h0;
   localparam [1:0] SRC_EXT = 2'h1;
   localparam [1:0] SRC_TRAP = 2'h2;

   wire realtime_flag = timer_status_control[`ETI_TSC_RTF];
   wire overflow_flag = timer_status_control[`ETI_TSC_OVF];
   wire realtime_int_en = timer_status_control[`ETI_TSC_RTE];
   wire overflow_int_en = timer_status_control[`ETI_TSC_OVE];
   wire porta_request_option = mask_option_reg[`ETI_OPT_PORTA];
   wire level_mode = mask_option_reg[`ETI_OPT_LEVEL];


   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // Single-word registers, so a full compare is all that is needed
   function addr_is;
      input [11:0] a;
      input [11:0] target;
      begin
         addr_is = (a == target);
      end
   endfunction

   wire hit_tsc = addr_is(paddr, `ETI_ADDR_TSC);
   wire hit_xsc = addr_is(paddr, `ETI_ADDR_XSC);
   wire hit_cpu = addr_is(paddr, `ETI_ADDR_CPU);
   wire hit_opt = addr_is(paddr, `ETI_ADDR_OPT);
   wire addr_ok = hit_tsc | hit_xsc | hit_cpu | hit_opt;

   // No wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   wire acc = psel & penable & clk_en;
   wire wr = acc & pwrite;
   // Unmapped accesses error out and write nothing
   assign pslverr = psel & penable & ~addr_ok;
   wire wr_tsc = wr & hit_tsc;
   wire wr_xsc = wr & hit_xsc;
   wire wr_opt = wr & hit_opt;

   // ----------------------------------------
   // External request detection
   // ----------------------------------------
   // Port A group is gated and ORed so one rising-edge detector serves all four pins
   wire pa_gate = porta_request_option & porta_group_enable;
   wire pa_any = pa_gate & (|pins_sync[4:1]);
   wire irq_act = ~pins_sync[0];
   wire irq_fall = irq_act & irq_prev; // irq_prev holds the previous high level
   wire pa_rise = pa_any & ~pa_prev;
   // Level term keeps the latch asserted while any source holds active
   wire level_hit = level_mode & (irq_act | pa_any);
   wire ext_set = irq_fall | pa_rise | level_hit;

   wire tmr_req = (realtime_flag & realtime_int_en) |
                  (overflow_flag & overflow_int_en);
   wire ext_take = ext_latch & ~int_mask;
   wire tmr_take = tmr_req & ~int_mask;

   // ----------------------------------------
   // Request arbitration
   // ----------------------------------------
   // Trap ignores the mask; pin outranks timers when both wait
   always @* begin
      next_src = SRC_TMR;
      next_take = 1'b0;
      if (software_trap) begin
         next_src = SRC_TRAP;
         next_take = 1'b1;
      end else if (ext_take) begin
         next_src = SRC_EXT;
         next_take = 1'b1;
      end else if (tmr_take) begin
         next_src = SRC_TMR;
         next_take = 1'b1;
      end
   end

   // ----------------------------------------
   // Illegal fetch detection
   // ----------------------------------------
   function in_range;
      input [10:0] a;
      input [10:0] lo;
      input [10:0] hi;
      begin
         in_range = (a >= lo) && (a <= hi);
      end
   endfunction

   wire fetch_bad = fetch_valid &
      ~in_range(fetch_addr, `ETI_RAM_LO, `ETI_RAM_HI) &
      ~in_range(fetch_addr, `ETI_ROM_LO, `ETI_ROM_HI);

   // Own process so a bad fetch is flagged in every sequencer state
   // One pulse per bad fetch cycle; the reset controller stretches it
   always @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         illegal_reset <= 1'b0;
      end else if (clk_en) begin
         illegal_reset <= fetch_bad;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state <= `ETI_ST_IDLE;
         src <= 2'h0;
         count <= 3'h0;
         int_mask <= 1'b1;
         stack_push <= 1'b0;
         stack_pop <= 1'b0;
         stack_index <= 3'h0;
         vector_load <= 1'b0;
         vector_addr <= 11'h000;
         in_service <= 1'b0;
      end else if (clk_en) begin
         stack_push <= 1'b0;
         stack_pop <= 1'b0;
         vector_load <= 1'b0;
         if (mask_set_cmd)
            int_mask <= 1'b1;
         else if (mask_clear_cmd && state == `ETI_ST_IDLE)
            int_mask <= 1'b0;
         case (state)
            ST_IDLE: begin
               // Return only counts while a service routine runs
               if (return_from_exception && in_service) begin
                  state <= ST_UNST;
                  count <= `ETI_STACK_BYTES;
               end else if (next_take) begin
                  // Source is frozen here so the vector matches the entry
                  src <= next_src;
                  state <= ST_STACK;
                  count <= 3'h0;
               end
            end
            `ETI_ST_STACK: begin
               stack_push <= 1'b1;
               stack_index <= count;
               if (count == `ETI_STACK_BYTES - 3'h1) begin
                  state <= `ETI_ST_VECT;
                  int_mask <= 1'b1;
               end
               count <= count + 3'h1;
            end
            `ETI_ST_VECT: begin
               vector_load <= 1'b1;
               in_service <= 1'b1;
               case (src)
                  2'h2: vector_addr <= `ETI_VEC_SWI;
                  2'h1: vector_addr <= `ETI_VEC_EXT;
                  default: vector_addr <= `ETI_VEC_TMR;
               endcase
               state <= `ETI_ST_IDLE;
            end
            `ETI_ST_UNST: begin
               stack_pop <= 1'b1;
               stack_index <= count - 3'h1;
               count <= count - 3'h1;
               if (count == 3'h1) begin
                  // Mask clears as the last byte returns, pending request follows
                  int_mask <= 1'b0;
                  in_service <= 1'b0;
                  state <= `ETI_ST_IDLE;
               end
            end
            default: state <= `ETI_ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // External latch and timer register
   // ----------------------------------------
   wire ext_clear = (state == `ETI_ST_VECT) && (src == 2'h1);
   always @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ext_latch <= 1'b0;
         // Idle-high pin level, so release cannot look like a fall
         irq_prev <= 1'b1;
         pa_prev <= 1'b0;
         timer_status_control <= `ETI_TSC_RESET;
         porta_group_enable <= 1'b0;
         mask_option_reg <= 2'h0;
      end else if (clk_en) begin
         irq_prev <= pins_sync[0];
         pa_prev <= pa_any;
         // New activity wins over the entry clear
         if (ext_set)
            ext_latch <= 1'b1;
         else if (ext_clear || (wr_xsc && pwdata[`ETI_XSC_ACK]))
            ext_latch <= 1'b0;
         if (wr_xsc)
            porta_group_enable <= pwdata[`ETI_XSC_GEN];
         if (wr_opt)
            mask_option_reg <= pwdata[1:0];
         if (wr_tsc) begin
            timer_status_control[`ETI_TSC_OVE] <= pwdata[`ETI_TSC_OVE];
            timer_status_control[`ETI_TSC_RTE] <= pwdata[`ETI_TSC_RTE];
            timer_status_control[1:0] <= pwdata[1:0];
         end
         // Flags: hardware set beats software clear
         if (overflow_event)
            timer_status_control[`ETI_TSC_OVF] <= 1'b1;
         else if (wr_tsc && pwdata[`ETI_TSC_OVCLR])
            timer_status_control[`ETI_TSC_OVF] <= 1'b0;
         if (realtime_event)
            timer_status_control[`ETI_TSC_RTF] <= 1'b1;
         else if (wr_tsc && pwdata[`ETI_TSC_RTCLR])
            timer_status_control[`ETI_TSC_RTF] <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Images mirror the bit layout software sees; unused bits read zero
   wire [31:0] tsc_image = {24'h000000, timer_status_control[7:4], 2'h0,
                            timer_status_control[1:0]};
   wire [31:0] xsc_image = {24'h000000, porta_group_enable, 3'h0, ext_latch, 3'h0};
   wire [31:0] cpu_image = {24'h000000, 3'h0, in_service, 2'h0, state};
   wire [31:0] opt_image = {30'h00000000, mask_option_reg};

   // Loaded in the setup cycle so the access cycle sees settled data
   always @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         prdata <= 32'h00000000;
      end else if (clk_en && psel && !penable && !pwrite) begin
         case (paddr)
            `ETI_ADDR_TSC: prdata <= tsc_image;
            `ETI_ADDR_XSC: prdata <= xsc_image;
            `ETI_ADDR_CPU: prdata <= cpu_image;
            `ETI_ADDR_OPT: prdata <= opt_image;
            default: prdata <= 32'h00000000;
         endcase
      end
   end
endmodule

// ---- eti_src.sv ----
module eti_src (
   input wire ref_clk,
   input wire lo,
   input wire [3:0] pa,
   output logic irq_pin_n,
   output logic [3:0] porta_low_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Wired sources, pin pulled up when idle
   // ----------------------------------------
   initial begin
      irq_pin_n = 1'b1;
      porta_low_pins = 4'h0;
   end
   always @(posedge ref_clk) begin
      irq_pin_n <= ~lo;
      porta_low_pins <= pa;
   end
endmodule

// ---- eti_assertions.sv ----
`include "eti_defs.vh"
module eti_chk (
   input wire ref_clk,
   input wire rst_n,
   input wire clk_en,
   input wire psel,
   input wire penable,
   input wire [11:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire fetch_valid,
   input wire [10:0] fetch_addr,
   input wire illegal_reset,
   input wire int_mask,
   input wire stack_push,
   input wire stack_pop,
   input wire [2:0] stack_index,
   input wire vector_load,
   input wire [10:0] vector_addr
);
   // ----------------------------------------
   // Fetch, entry and return sequencing, bus response and reset mask
   // ----------------------------------------
   wire in_ram = fetch_addr >= `ETI_RAM_LO && fetch_addr <= `ETI_RAM_HI;
   wire bad = !(in_ram || fetch_addr >= `ETI_ROM_LO);
   wire acc = psel && penable;
   wire map = paddr inside {`ETI_ADDR_TSC, `ETI_ADDR_XSC, `ETI_ADDR_CPU, `ETI_ADDR_OPT};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence push_last;
      stack_push && stack_index == 3'h4;
   endsequence
   sequence pop_last;
      stack_pop && stack_index == 3'h0;
   endsequence
   chk_bad_fetch: assert property (clk_en && fetch_valid && bad |=> illegal_reset)
      else $error("bad fetch gave no reset");
   chk_no_spur: assert property (illegal_reset |-> $past(fetch_valid && bad))
      else $error("reset without bad fetch");
   chk_push_order: assert property (clk_en && stack_push && stack_index < 3'h4 |=>
      stack_push && stack_index == $past(stack_index) + 3'h1)
      else $error("push order broken");
   chk_vec_follows: assert property (push_last |=> vector_load)
      else $error("no vector after pushes");
   chk_vec_masked: assert property (vector_load |-> int_mask)
      else $error("vector with mask clear");
   chk_vec_fixed: assert property (vector_load |->
      vector_addr inside {`ETI_VEC_SWI, `ETI_VEC_EXT, `ETI_VEC_TMR})
      else $error("vector address wrong");
   chk_pop_order: assert property (stack_pop && stack_index > 3'h0 |=>
      stack_pop && stack_index == $past(stack_index) - 3'h1)
      else $error("pop order broken");
   chk_pop_unmask: assert property (pop_last |-> ##[0:1] !int_mask)
      else $error("mask kept after return");
   chk_apb_resp: assert property (acc |-> pready && pslverr == !map)
      else $error("apb response wrong");
   chk_reset_mask: assert property ($rose(rst_n) |-> int_mask)
      else $error("mask clear after reset");
endmodule
bind eti_core eti_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
   .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .illegal_reset(illegal_reset),
   .int_mask(int_mask), .stack_push(stack_push), .stack_pop(stack_pop),
   .stack_index(stack_index), .vector_load(vector_load), .vector_addr(vector_addr));

// ---- ext_timer_interrupt_logic_bench.sv ----
`include "eti_defs.vh"
module ext_timer_interrupt_logic_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er, lo = 0, fv = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [3:0] pa = 0, p;
   logic [5:0] cmd = 0;
   logic [10:0] fa = 0;
   wire [31:0] prdata;
   wire pready, pslverr, illegal_reset, int_mask, stack_push, stack_pop, vector_load, in_service;
   wire irq_pin_n;
   wire [2:0] stack_index;
   wire [10:0] vector_addr;
   wire [3:0] porta_low_pins;
   int miscompares = 0, n_checks = 0, cyc = 0, seed = 45266, n, i;
   eti_core dut_u (.ref_clk, .rst_n, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .irq_pin_n, .porta_low_pins, .realtime_event(cmd[4]),
      .overflow_event(cmd[5]), .software_trap(cmd[3]), .return_from_exception(cmd[2]),
      .mask_set_cmd(cmd[1]), .mask_clear_cmd(cmd[0]), .fetch_valid(fv), .fetch_addr(fa),
      .illegal_reset, .int_mask, .stack_push, .stack_pop, .stack_index, .vector_load,
      .vector_addr, .in_service);
   eti_src src_u (.ref_clk, .lo, .pa, .irq_pin_n, .porta_low_pins);
   initial forever #4 ref_clk = ~ref_clk;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
      @(posedge ref_clk);
      penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task pulse(input logic [5:0] m);
      @(posedge ref_clk);
      cmd <= m;
      @(posedge ref_clk);
      cmd <= 0;
   endtask
   task pin(input logic l, input logic [3:0] q);
      @(posedge ref_clk);
      lo <= l;
      pa <= q;
      repeat (6) @(posedge ref_clk);
   endtask
   task xpend(input logic e);
      apb(0, `ETI_ADDR_XSC, 0);
      chk("pending", 32'(rd[`ETI_XSC_PEND]), 32'(e));
   endtask
   task ent(input logic [10:0] v);
      n = 0;
      i = 0;
      do begin
         @(negedge ref_clk);
         n += int'(stack_push === 1'b1);
         i++;
      end while (vector_load !== 1'b1 && i < 80);
      chk("vector", 32'(vector_addr), 32'(v));
      chk("pushes", n, 5);
      chk("mask", 32'(int_mask), 1);
   endtask
   task ret;
      pulse(6'h04);
      i = 0;
      do begin
         @(negedge ref_clk);
         i++;
      end while (!(stack_pop === 1'b1 && stack_index === 3'h0) && i < 40);
      @(negedge ref_clk);
      chk("unmask", 32'(int_mask), 0);
   endtask
   always @(posedge ref_clk)
      if (++cyc == 20000) begin
         miscompares++;
         tally_and_finish;
      end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1;
      repeat (3) @(posedge ref_clk);
      chk("rst mask", 32'(int_mask), 1);
      apb(0, `ETI_ADDR_TSC, 0);
      chk("tsc reset", rd, 32'(`ETI_TSC_RESET));
      apb(0, 12'h020, 0);
      chk("unmapped", 32'(er), 1);
      apb(1, `ETI_ADDR_OPT, 0);
      pin(1, 0);
      xpend(1);
      chk("idle", 32'(in_service), 0);
      pulse(6'h01);
      ent(`ETI_VEC_EXT);
      xpend(0);
      pin(0, 0);
      pin(1, 0);
      xpend(1);
      ret;
      ent(`ETI_VEC_EXT);
      pin(0, 0);
      ret;
      apb(1, `ETI_ADDR_OPT, 1);
      pin(1, 0);
      ent(`ETI_VEC_EXT);
      xpend(1);
      pin(0, 0);
      ret;
      ent(`ETI_VEC_EXT);
      xpend(0);
      ret;
      pulse(6'h02);
      p = 4'($random(seed)) | 4'h1;
      apb(1, `ETI_ADDR_OPT, 2);
      apb(1, `ETI_ADDR_XSC, 32'h80);
      pin(0, p);
      xpend(1);
      apb(1, `ETI_ADDR_XSC, 32'h82);
      pin(0, 0);
      apb(1, `ETI_ADDR_XSC, 0);
      pin(0, p);
      xpend(0);
      pin(0, 0);
      apb(1, `ETI_ADDR_XSC, 32'h80);
      apb(1, `ETI_ADDR_OPT, 0);
      pin(0, p);
      xpend(0);
      apb(1, `ETI_ADDR_OPT, 3);
      apb(1, `ETI_ADDR_XSC, 32'h82);
      xpend(1);
      pin(0, 0);
      apb(1, `ETI_ADDR_XSC, 32'h82);
      xpend(0);
      apb(1, `ETI_ADDR_TSC, 32'h20);
      pulse(6'h20);
      repeat (10) @(posedge ref_clk);
      chk("masked", 32'(in_service), 0);
      pulse(6'h01);
      ent(`ETI_VEC_TMR);
      apb(0, `ETI_ADDR_TSC, 0);
      chk("ovf flag", 32'(rd[7:4]), 32'h0a);
      apb(1, `ETI_ADDR_TSC, 32'h28);
      ret;
      apb(1, `ETI_ADDR_TSC, 32'h10);
      pulse(6'h10);
      ent(`ETI_VEC_TMR);
      apb(1, `ETI_ADDR_TSC, 32'h14);
      ret;
      pulse(6'h08);
      ent(`ETI_VEC_SWI);
      ret;
      for (int k = 0; k < 40; k++) begin
         @(posedge ref_clk);
         fv <= 1;
         fa <= 11'($random(seed));
         @(posedge ref_clk);
         @(negedge ref_clk);
         n = int'(!((fa >= `ETI_RAM_LO && fa <= `ETI_RAM_HI) || fa >= `ETI_ROM_LO));
         chk("illegal", 32'(illegal_reset), n);
      end
      fv <= 0;
      tally_and_finish;
   end
endmodule
